/* File: tb_top.sv */
// self-checking bench for the recovery controller with a flash model
// assumes AHB-Lite single word transfers and a shortened power wait
`timescale 1ns/1ps

module tb_top;
  logic        clk, nrst, pwr_ok, hwrite, hready, hresp;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic        sclk, cs_n, rst_n, d0o, d0oe, d3o, d3oe, d0m, d3m;
  logic [3:0]  c;
  logic [3:0]  tab[11] = '{4'h8, 4'h2, 4'h8, 4'h1, 4'h8, 4'h0, 4'h8, 4'h3, 4'h8, 4'h4, 4'hc};
  int          bad_count, n_tests, i, n;
  wire         dq0 = d0oe ? d0m : d0o;
  wire         dq3 = d3oe ? d3m : d3o;

  xpr_host #(.POWER_WAIT_CYC(20)) uut
  (
    .clk(clk), .nrst(nrst), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .flash_sclk(sclk), .flash_cs_n(cs_n), .flash_reset_n(rst_n),
    .serial_data_line_0_in(dq0), .serial_data_line_0_out(d0o), .serial_data_line_0_oe_n(d0oe),
    .data_line_3_hold_in(dq3), .data_line_3_hold_out(d3o), .data_line_3_hold_oe_n(d3oe)
  );
  xpr_flash_model m
  (
    .clk(clk), .pwr_ok(pwr_ok), .sclk(sclk), .cs_n(cs_n), .reset_n(rst_n),
    .dq0(dq0), .dq3(dq3), .dq0_drv(d0m), .dq3_drv(d3m)
  );

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // one transfer; entered right after a rising edge
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
    int k;
    k = 0;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1 && ++k < 100);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1 && ++k < 100);
    rd = hrdata;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("FAIL %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // expected clock count of frame i of an operation, 0 past the end
  function automatic int exp_len(input int op, input int pr, input int i);
    int rec[7] = '{7, 9, 13, 17, 25, 33, 8};
    int ext[3] = '{25, 13, 7};
    int k;
    k = i;
    if (op == 0 && pr < 3)
    begin
      if (k == 0)
        return ext[pr];
      k = k + 6;
    end
    if (op == 3)
      k = k + 7;
    if (op == 2 || (op != 1 && k > 8) || (op == 1 && k > 6))
      return 0;
    return k < 7 ? rec[k] : 8;
  endfunction

  task automatic run_op(input int op, input int pr, input logic [7:0] re, input logic [7:0] rm);
    logic [31:0] q;
    int          f0, r0, t, ncmd, j;
    f0   = m.n_frames;
    r0   = m.rst_count;
    ncmd = (op == 0 || op == 3) ? 2 : 0;
    bus(32'h8, 1'b1, {16'h0, rm, re}, q);
    bus(32'h8, 1'b0, 32'h0, q);
    chk(q, {16'h0, rm, re}, "command codes");
    bus(32'h0, 1'b1, 32'(op * 4 + pr * 16 + 1), q);
    bus(32'h0, 1'b0, 32'h0, q);
    chk(q, 32'(op * 4 + pr * 16), "control readback");
    bus(32'h0, 1'b1, 32'h5, q);
    j = 0;
    do bus(32'h4, 1'b0, 32'h0, q); while (q[1:0] !== 2'b10 && ++j < 5000);
    for (t = 0; exp_len(op, pr, t) > 0; t++);
    chk(q & 32'hf07, 32'h6 + 32'((t > 0 ? t - 1 : 0) * 256), "done status");
    chk(32'(m.n_frames - f0), 32'(t), "frame count");
    for (j = 0; j < t; j++)
    begin
      chk(32'(m.len_log[f0 + j]), 32'(exp_len(op, pr, j)), "frame length");
      if (j < t - ncmd)
        chk({31'h0, m.ones_log[f0 + j]}, 32'h1, "lines held high");
    end
    if (ncmd == 2)
    begin
      chk({24'h0, m.byte_log[f0 + t - 2]}, {24'h0, re}, "reset enable byte");
      chk({24'h0, m.byte_log[f0 + t - 1]}, {24'h0, rm}, "reset memory byte");
    end
    if (op == 2)
      chk(32'(m.rst_count - r0), 32'h1, "reset pulses");
    if (op != 3)
      chk({31'h0, m.xip_on}, 32'(op == 2), "execute in place state");
  endtask

  initial
  begin
    nrst      = 1'b0;
    pwr_ok    = 1'b0;
    htrans    = 2'h0;
    haddr     = 32'h0;
    hwrite    = 1'b0;
    hwdata    = 32'h0;
    bad_count = 0;
    n_tests   = 0;
    n         = $urandom(32'h41cc4338);
    repeat (4) @(posedge clk);
    nrst   <= 1'b1;
    pwr_ok <= 1'b1;
    repeat (3) @(posedge clk);
    bus(32'h4, 1'b0, 32'h0, r);
    chk(r & 32'h4, 32'h0, "ready too early");
    bus(32'h0, 1'b1, 32'h5, r);
    bus(32'h8, 1'b0, 32'h0, r);
    chk(r, 32'h0, "command reset value");
    bus(32'h10, 1'b1, 32'hffffffff, r);
    bus(32'h10, 1'b0, 32'h0, r);
    chk(r, 32'h0, "unmapped read");
    n = 0;
    do bus(32'h4, 1'b0, 32'h0, r); while (r[2] !== 1'b1 && ++n < 100);
    chk(r & 32'h4, 32'h4, "ready");
    chk(32'(m.n_frames), 32'h0, "start before ready");
    for (i = 0; i < 16; i++)
    begin
      c = (i < 11) ? tab[i] : 4'($urandom_range(15));
      run_op(int'(c[3:2]), int'(c[1:0]), 8'($urandom & 8'h7f), 8'($urandom & 8'h7f));
    end
    final_report;
  end

  initial
  begin
    #2000000;
    bad_count++;
    final_report;
  end
endmodule

/* File: xpr_defs.svh */
// constants for the execute-in-place exit and power-loss recovery controller
// assumes a 50 MHz system clock; included by the frame engine and host modules
`ifndef XPR_DEFS_SVH
`define XPR_DEFS_SVH

// system clock period
`define XPR_CLK_NS           20
// serial clock half period in system clocks (80 ns serial clock)
`define XPR_SCK_HALF_CYC     2
// least deselect time between frames, in ns, and rounded up to cycles
`define XPR_DESELECT_TIME_NS 50
`define XPR_DESELECT_CYC     ((`XPR_DESELECT_TIME_NS + `XPR_CLK_NS - 1) / `XPR_CLK_NS)
// least hardware reset pulse width, in ns, and rounded up to cycles
`define XPR_RESET_PULSE_NS   50
`define XPR_RESET_PULSE_CYC  ((`XPR_RESET_PULSE_NS + `XPR_CLK_NS - 1) / `XPR_CLK_NS)
// longest reset recovery time after array operations, in us, and in cycles
`define XPR_RECOVERY_US      30
`define XPR_RECOVERY_CYC     ((`XPR_RECOVERY_US * 1000) / `XPR_CLK_NS)
// power to write time, in us, and in cycles
`define XPR_POWER_TO_WRITE_US  150
`define XPR_POWER_TO_WRITE_CYC ((`XPR_POWER_TO_WRITE_US * 1000) / `XPR_CLK_NS)

// exit frame lengths per protocol width, in serial clocks
`define XPR_EXIT_QUAD_CLK    7
`define XPR_EXIT_DUAL_CLK    13
`define XPR_EXIT_EXT_CLK     25
// power-loss recovery frame lengths, in serial clocks
`define XPR_REC_LEN0         7
`define XPR_REC_LEN1         9
`define XPR_REC_LEN2         13
`define XPR_REC_LEN3         17
`define XPR_REC_LEN4         25
`define XPR_REC_LEN5         33
`define XPR_REC_PART2_CLK    8
`define XPR_REC_FRAMES       7
`define XPR_ALL_ONES_BYTE    8'hff
`define XPR_BYTE_CLK         8

// register byte offsets
`define XPR_REG_CTRL         8'h00
`define XPR_REG_STATUS       8'h04
`define XPR_REG_CMDS         8'h08
// control register fields
`define XPR_CTRL_START       0
`define XPR_CTRL_OP_LSB      2
`define XPR_CTRL_PROTO_LSB   4
// command register reset value
`define XPR_CMDS_RESET       16'h0000

`endif

/* File: xpr_flash_model.sv */
// behavioural serial flash: logs frames and tracks execute-in-place
// assumes line levels are resolved by the bench from the host's output enables
`timescale 1ns/1ps

module xpr_flash_model
(
  // clock for the released-line pattern
  input  wire logic clk,
  input  wire logic pwr_ok,
  // serial link
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic reset_n,
  input  wire logic dq0,
  input  wire logic dq3,
  // levels shown on released lines
  output logic      dq0_drv,
  output logic      dq3_drv
);
  logic       xip_on    = 1'b1;
  logic       ones;
  logic [7:0] shift;
  int         clk_cnt   = 0;
  int         n_frames  = 0;
  int         rst_count = 0;
  int         len_log[64];
  logic [7:0] byte_log[64];
  logic       ones_log[64];

  // a released line never holds its last level
  always @(posedge clk)
  begin
    dq0_drv <= (dq0 === 1'b1) ? 1'b0 : 1'b1;
    dq3_drv <= (dq3 === 1'b1) ? 1'b0 : 1'b1;
  end
  always @(negedge cs_n)
  begin
    clk_cnt = 0;
    ones    = 1'b1;
    shift   = 8'h00;
  end
  // nothing but a reset pulse is decoded below the supply threshold
  always @(posedge sclk)
    if (!cs_n && pwr_ok)
    begin
      if (clk_cnt < 8)
        shift = {shift[6:0], dq0};
      ones = ones & dq0 & dq3;
      clk_cnt++;
    end
  // an all-ones frame ends execute-in-place; no reset, no abort
  always @(posedge cs_n)
    if (pwr_ok && clk_cnt > 0 && n_frames < 64)
    begin
      len_log[n_frames]  = clk_cnt;
      byte_log[n_frames] = shift;
      ones_log[n_frames] = ones;
      if (ones)
        xip_on = 1'b0;
      n_frames++;
      clk_cnt = 0;
    end
  // reset pulse restores the power-on state at once
  always @(negedge reset_n)
  begin
    rst_count++;
    xip_on = 1'b1;
  end
endmodule

/* File: xpr_frame.sv */
// frame engine: one chip-select frame of a given number of serial clocks
// assumes a start pulse only while busy is low; serial clock is derived from clk
`timescale 1ns/1ps
`include "xpr_defs.svh"

module xpr_frame
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // frame request
  input  wire logic               start,
  input  wire xpr_pkg::xpr_frame_t frame,
  output logic                    busy,
  // flash pins
  output xpr_pkg::xpr_pins_t      pins
);

  typedef struct packed {
    xpr_pkg::xpr_fphase_t phase;
    logic [3:0]           cnt;
    logic [5:0]           left;
    logic [7:0]           shreg;
    xpr_pkg::xpr_pins_t   pins;
  } xpr_frame_state_t;

  localparam logic [3:0] HALF   = 4'(`XPR_SCK_HALF_CYC - 1);
  localparam logic [3:0] DESEL  = 4'(`XPR_DESELECT_CYC - 1);
  localparam xpr_pkg::xpr_pins_t IDLE_PINS = '{sclk: 1'b0, cs_n: 1'b1, dq0_out: 1'b0,
                                               dq0_oe_n: 1'b1, dq3_out: 1'b0, dq3_oe_n: 1'b1};

  xpr_frame_state_t r;
  xpr_frame_state_t next_r;

  always_comb
  begin
    next_r = r;
    unique case (r.phase)
      xpr_pkg::F_IDLE:
      begin
        if (start)
        begin
          // data line 0 carries the byte msb first, ones after it; data line 3 held high
          next_r.phase         = xpr_pkg::F_SETUP;
          next_r.cnt           = HALF;
          next_r.left          = frame.len;
          next_r.shreg         = frame.data;
          next_r.pins.cs_n     = 1'b0;
          next_r.pins.dq0_out  = frame.data[7];
          next_r.pins.dq0_oe_n = 1'b0;
          next_r.pins.dq3_out  = 1'b1; // [R12] [R14]
          next_r.pins.dq3_oe_n = 1'b0;
        end
      end
      xpr_pkg::F_SETUP, xpr_pkg::F_LOW:
      begin
        if (r.cnt == 4'h0)
        begin
          next_r.phase     = xpr_pkg::F_HIGH;
          next_r.cnt       = HALF;
          next_r.left      = r.left - 6'h01;
          next_r.pins.sclk = 1'b1;
        end
        else
        begin
          next_r.cnt = r.cnt - 4'h1;
        end
      end
      xpr_pkg::F_HIGH:
      begin
        if (r.cnt != 4'h0)
        begin
          next_r.cnt = r.cnt - 4'h1;
        end
        else if (r.left == 6'h00)
        begin
          // chip select rises with the clock low, before another rising edge
          next_r.phase = xpr_pkg::F_GAP; // [R02] [R03] [R04] [R12] [R14]
          next_r.cnt   = DESEL;
          next_r.pins  = IDLE_PINS;
        end
        else
        begin
          next_r.phase        = xpr_pkg::F_LOW;
          next_r.cnt          = HALF;
          next_r.shreg        = {r.shreg[6:0], 1'b1};
          next_r.pins.sclk    = 1'b0;
          next_r.pins.dq0_out = r.shreg[6];
        end
      end
      xpr_pkg::F_GAP:
      begin
        // deselect time kept after every frame, so also before the next one
        if (r.cnt == 4'h0)
        begin
          next_r.phase = xpr_pkg::F_IDLE; // [R13] [R26]
        end
        else
        begin
          next_r.cnt = r.cnt - 4'h1;
        end
      end
      default:
      begin
        next_r.phase = xpr_pkg::F_IDLE;
        next_r.pins  = IDLE_PINS;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r.phase <= xpr_pkg::F_IDLE;
      r.cnt   <= 4'h0;
      r.left  <= 6'h00;
      r.shreg <= 8'h00;
      r.pins  <= IDLE_PINS;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign busy = (r.phase != xpr_pkg::F_IDLE);
  assign pins = r.pins;

endmodule

/* File: xpr_host.sv */
// host controller that takes a serial NOR flash out of execute-in-place and recovers it
// assumes an AHB-Lite master with single word transfers and one flash on the pins below
`timescale 1ns/1ps
`include "xpr_defs.svh"

// What the document requires
// (R01) If host resets alone, it may pulse the flash reset to restore power-on state.
// (R02) Quad exit: data line 0 high, chip select low seven clocks, rise before eighth.
// (R03) Dual exit: data line 0 high, chip select low 13 clocks, rise before fourteenth.
// (R04) Extended exit: data line 0 high for 25 clocks, rise before twenty-sixth.
// (R05) Flash takes the exit as confirm bit one; no reset, operations continue.
// (R06) After an exit, host sends reset-enable then reset-memory commands.
// (R07) Below power-on threshold the flash stays in reset and ignores everything.
// (R08) During power-up the flash answers only status and flag status reads.
// (R09) After power-up: standby, write latch and busy cleared, lock bits zero.
// (R10) Flash fully accessible no later than 150 us after supply reaches minimum.
// (R11) Below threshold at power-down the flash disables all operations.
// (R12) Recovery part one: frames of 7,9,13,17,25,33 clocks, lines 0 and 3 high.
// (R13) At least 50 ns deselect between all frames of the recovery.
// (R14) Recovery part two: all-ones byte, eight clocks, chip select rises before ninth.
// (R15) Both recovery parts run in order after a lost configuration write.
// (R16) After recovery the flash is in extended single-line protocol, no execute-in-place.
// (R17) Software should then rewrite the nonvolatile configuration register.
// (R18) Hardware reset pulse held low at least 50 ns.
// (R19) After reset pulse from idle or volatile work, flash ready within 40 ns.
// (R20) Reset during array program or erase recovers within 30 us.
// (R21) Reset during status, configuration write or subsector erase waits that operation.
// (R22) Software reset recovery 90 ns from standby, 30 us after program or erase.
// (R23) Confirm bit is data line 0 in first dummy clock; one exits, zero stays.
// (R24) In execute-in-place each frame carries only address bits, no command.
// (R25) Exit length follows active protocol; unknown protocol uses full recovery.
// (R26) Clock idle and chip select high for the deselect time before any frame.
module xpr_host
#(
  parameter int POWER_WAIT_CYC = `XPR_POWER_TO_WRITE_CYC
)
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // flash serial link
  output logic             flash_sclk,
  output logic             flash_cs_n,
  output logic             flash_reset_n,
  // serial data line 0, two-way
  input  wire logic        serial_data_line_0_in,
  output logic             serial_data_line_0_out,
  output logic             serial_data_line_0_oe_n,
  // data line 3 (hold), two-way
  input  wire logic        data_line_3_hold_in,
  output logic             data_line_3_hold_out,
  output logic             data_line_3_hold_oe_n
);

  typedef struct packed {
    xpr_pkg::xpr_mstate_t st;
    logic [12:0]          cnt;
    logic [3:0]           step;
    xpr_pkg::xpr_op_t     op;
    xpr_pkg::xpr_proto_t  proto;
    logic                 done;
    logic                 ready;
    logic [15:0]          cmds;
    logic                 rst_out;
    logic                 ap_valid;
    logic                 ap_write;
    logic [7:0]           ap_addr;
    logic [31:0]          rdata;
    logic [2:0]           sync0;
    logic [2:0]           sync3;
    logic                 dq0_lvl;
    logic                 dq3_lvl;
  } xpr_host_state_t;

  localparam logic [12:0] RESET_PULSE = 13'(`XPR_RESET_PULSE_CYC - 1);
  localparam logic [12:0] RECOVERY    = 13'(`XPR_RECOVERY_CYC - 1);
  localparam logic [12:0] POWER_WAIT  = 13'(POWER_WAIT_CYC - 1);

  // reset release through two flip-flops
  logic [1:0] rst_sync;
  logic       rst_n;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_sync <= 2'b00;
    end
    else
    begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rst_n = rst_sync[1];

  xpr_host_state_t     r;
  xpr_host_state_t     next_r;
  logic                fr_start;
  logic                fr_busy;
  xpr_pkg::xpr_frame_t fr;
  xpr_pkg::xpr_pins_t  pins;
  logic                fr_last;
  logic                busy;
  logic                rec;
  logic                cmds_due;
  logic [3:0]          n_pre;
  logic [3:0]          n_total;
  logic [3:0]          cmd_idx;
  logic                ap_sel;

  // recovery part one lengths by frame index, part two as the last
  function automatic logic [5:0] rec_len(input logic [3:0] idx);
    logic [5:0] len;
    len = 6'(`XPR_REC_PART2_CLK);
    unique case (idx)
      4'h0: len = 6'(`XPR_REC_LEN0);
      4'h1: len = 6'(`XPR_REC_LEN1);
      4'h2: len = 6'(`XPR_REC_LEN2);
      4'h3: len = 6'(`XPR_REC_LEN3);
      4'h4: len = 6'(`XPR_REC_LEN4);
      4'h5: len = 6'(`XPR_REC_LEN5);
      default: len = 6'(`XPR_REC_PART2_CLK);
    endcase
    return len;
  endfunction

  // exit frame length matching the active protocol width
  function automatic logic [5:0] exit_len(input xpr_pkg::xpr_proto_t p);
    logic [5:0] len;
    len = 6'(`XPR_EXIT_EXT_CLK);
    unique case (p)
      xpr_pkg::PR_QUAD: len = 6'(`XPR_EXIT_QUAD_CLK); // [R02]
      xpr_pkg::PR_DUAL: len = 6'(`XPR_EXIT_DUAL_CLK); // [R03]
      xpr_pkg::PR_EXT:  len = 6'(`XPR_EXIT_EXT_CLK);  // [R04]
      default:          len = 6'(`XPR_EXIT_EXT_CLK);
    endcase
    return len;
  endfunction

  // frame plan of the running order
  always_comb
  begin
    rec      = (r.op == xpr_pkg::OP_RECOVER) ||
               (r.op == xpr_pkg::OP_EXIT && r.proto == xpr_pkg::PR_UNKNOWN); // [R25]
    cmds_due = (r.op == xpr_pkg::OP_EXIT) || (r.op == xpr_pkg::OP_SWRST);    // [R06]
    if (rec)
    begin
      n_pre = 4'(`XPR_REC_FRAMES);
    end
    else if (r.op == xpr_pkg::OP_EXIT)
    begin
      n_pre = 4'h1;
    end
    else
    begin
      n_pre = 4'h0;
    end
    n_total = n_pre + (cmds_due ? 4'h2 : 4'h0);
    cmd_idx = r.step - n_pre;
    fr_last = (r.step == n_total - 4'h1);
    if (r.step < n_pre)
    begin
      // data line 0 held high throughout, the confirm bit reads as one
      fr.data = `XPR_ALL_ONES_BYTE; // [R05] [R14] [R23]
      fr.len  = rec ? rec_len(r.step) : exit_len(r.proto); // [R12] [R15]
    end
    else
    begin
      // reset-enable first, then reset-memory, both in extended single-line form
      fr.data = (cmd_idx == 4'h0) ? r.cmds[7:0] : r.cmds[15:8]; // [R06]
      fr.len  = 6'(`XPR_BYTE_CLK);
    end
  end

  assign fr_start = (r.st == xpr_pkg::M_FRAME);
  assign busy     = (r.st != xpr_pkg::M_IDLE) && (r.st != xpr_pkg::M_POWER);
  assign ap_sel   = hsel && htrans[1] && hready;

  always_comb
  begin
    next_r = r;

    // pin inputs: three flops, a change counts once the last two agree
    next_r.sync0 = {r.sync0[1:0], serial_data_line_0_in};
    next_r.sync3 = {r.sync3[1:0], data_line_3_hold_in};
    if (r.sync0[1] == r.sync0[2])
    begin
      next_r.dq0_lvl = r.sync0[2];
    end
    if (r.sync3[1] == r.sync3[2])
    begin
      next_r.dq3_lvl = r.sync3[2];
    end

    // address phase capture and registered read data
    next_r.ap_valid = ap_sel;
    next_r.ap_write = hwrite;
    next_r.ap_addr  = haddr[7:0];
    next_r.rdata    = 32'h0000_0000;
    if (ap_sel && !hwrite)
    begin
      unique case (haddr[7:0])
        `XPR_REG_CTRL:   next_r.rdata = {26'h0, r.proto, r.op, 2'b00};
        `XPR_REG_STATUS: next_r.rdata = {20'h0, r.step, 3'h0, r.dq3_lvl, r.dq0_lvl,
                                         r.ready, r.done, busy};
        `XPR_REG_CMDS:   next_r.rdata = {16'h0, r.cmds};
        default:         next_r.rdata = 32'h0000_0000;
      endcase
    end

    unique case (r.st)
      xpr_pkg::M_POWER:
      begin
        // no frame before the flash is fully accessible
        if (r.cnt == 13'h0000)
        begin
          next_r.ready = 1'b1; // [R10]
          next_r.st    = xpr_pkg::M_IDLE;
        end
        else
        begin
          next_r.cnt = r.cnt - 13'h0001;
        end
      end
      xpr_pkg::M_IDLE:
      begin
        if (r.ap_valid && r.ap_write && r.ap_addr == `XPR_REG_CMDS)
        begin
          next_r.cmds = hwdata[15:0];
        end
        if (r.ap_valid && r.ap_write && r.ap_addr == `XPR_REG_CTRL && hwdata[`XPR_CTRL_START])
        begin
          next_r.op    = xpr_pkg::xpr_op_t'(hwdata[`XPR_CTRL_OP_LSB +: 2]);
          next_r.proto = xpr_pkg::xpr_proto_t'(hwdata[`XPR_CTRL_PROTO_LSB +: 2]);
          next_r.step  = 4'h0;
          next_r.done  = 1'b0;
          if (xpr_pkg::xpr_op_t'(hwdata[`XPR_CTRL_OP_LSB +: 2]) == xpr_pkg::OP_HWRST)
          begin
            next_r.st      = xpr_pkg::M_RSTLOW; // [R01]
            next_r.cnt     = RESET_PULSE;
            next_r.rst_out = 1'b0;
          end
          else
          begin
            next_r.st = xpr_pkg::M_FRAME;
          end
        end
      end
      xpr_pkg::M_RSTLOW:
      begin
        if (r.cnt == 13'h0000)
        begin
          next_r.rst_out = 1'b1; // [R18]
          next_r.st      = xpr_pkg::M_RECOV;
          next_r.cnt     = RECOVERY; // [R19] [R20]
        end
        else
        begin
          next_r.cnt = r.cnt - 13'h0001;
        end
      end
      xpr_pkg::M_FRAME:
      begin
        next_r.st = xpr_pkg::M_FWAIT;
      end
      xpr_pkg::M_FWAIT:
      begin
        if (!fr_busy)
        begin
          if (fr_last)
          begin
            next_r.st  = xpr_pkg::M_RECOV;
            next_r.cnt = cmds_due ? RECOVERY : 13'h0000; // [R22]
          end
          else
          begin
            next_r.step = r.step + 4'h1; // [R15]
            next_r.st   = xpr_pkg::M_FRAME;
          end
        end
      end
      xpr_pkg::M_RECOV:
      begin
        if (r.cnt == 13'h0000)
        begin
          next_r.done = 1'b1; // [R17]
          next_r.st   = xpr_pkg::M_IDLE;
        end
        else
        begin
          next_r.cnt = r.cnt - 13'h0001;
        end
      end
      default:
      begin
        next_r.st = xpr_pkg::M_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r.st       <= xpr_pkg::M_POWER;
      r.cnt      <= POWER_WAIT;
      r.step     <= 4'h0;
      r.op       <= xpr_pkg::OP_EXIT;
      r.proto    <= xpr_pkg::PR_EXT;
      r.done     <= 1'b0;
      r.ready    <= 1'b0;
      r.cmds     <= `XPR_CMDS_RESET;
      r.rst_out  <= 1'b1;
      r.ap_valid <= 1'b0;
      r.ap_write <= 1'b0;
      r.ap_addr  <= 8'h00;
      r.rdata    <= 32'h0000_0000;
      r.sync0    <= 3'h0;
      r.sync3    <= 3'h0;
      r.dq0_lvl  <= 1'b0;
      r.dq3_lvl  <= 1'b0;
    end
    else
    begin
      r <= next_r;
    end
  end

  xpr_frame u_frame
  (
    .clk   (clk),
    .rst_n (rst_n),
    .start (fr_start),
    .frame (fr),
    .busy  (fr_busy),
    .pins  (pins)
  );

  assign hreadyout               = 1'b1;
  assign hresp                   = 1'b0;
  assign hrdata                  = r.rdata;
  assign flash_sclk              = pins.sclk;
  assign flash_cs_n              = pins.cs_n;
  assign flash_reset_n           = r.rst_out;
  assign serial_data_line_0_out  = pins.dq0_out;
  assign serial_data_line_0_oe_n = pins.dq0_oe_n;
  assign data_line_3_hold_out    = pins.dq3_out;
  assign data_line_3_hold_oe_n   = pins.dq3_oe_n;

endmodule

/* File: xpr_host_asserts.sv */
// concurrent checks on the flash pins of the recovery controller
// assumes binding into xpr_host; one clock domain, raw nrst as disable
`timescale 1ns/1ps

module xpr_host_asserts
#(
  parameter int POWER_WAIT_CYC = 20
)
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // flash pins
  input wire logic flash_sclk,
  input wire logic flash_cs_n,
  input wire logic flash_reset_n,
  input wire logic serial_data_line_0_out,
  input wire logic serial_data_line_0_oe_n,
  input wire logic data_line_3_hold_out,
  input wire logic data_line_3_hold_oe_n
);
  logic        sclk_q;
  logic [5:0]  n_clk;
  logic [15:0] pwr_cnt;

  // serial clock rises counted within the current frame
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sclk_q  <= 1'b0;
      n_clk   <= 6'h00;
      pwr_cnt <= 16'h0000;
    end
    else
    begin
      sclk_q  <= flash_sclk;
      n_clk   <= flash_cs_n ? 6'h00 : n_clk + 6'(flash_sclk & ~sclk_q);
      pwr_cnt <= (pwr_cnt == 16'hffff) ? pwr_cnt : pwr_cnt + 16'h0001;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_sclk_idle_desel: assert property (flash_cs_n |-> !flash_sclk)
    else $error("serial clock moves while deselected");
  a_gap_after_frame: assert property ($rose(flash_cs_n) |-> flash_cs_n[*3])
    else $error("deselect gap shorter than three cycles");
  a_frame_len_legal: assert property ($rose(flash_cs_n)
    |-> n_clk inside {7, 8, 9, 13, 17, 25, 33})
    else $error("frame clock count not a legal length");
  a_dq3_held_high: assert property (!flash_cs_n |-> !data_line_3_hold_oe_n && data_line_3_hold_out)
    else $error("line 3 not driven high inside a frame");
  a_lines_released: assert property (flash_cs_n |-> serial_data_line_0_oe_n && data_line_3_hold_oe_n)
    else $error("data line driven while deselected");
  a_tail_ones: assert property (!flash_cs_n && flash_sclk && !sclk_q && n_clk >= 6'd8
    |-> serial_data_line_0_out)
    else $error("clock past the eighth carries zero");
  a_rst_width: assert property ($fell(flash_reset_n) |-> !flash_reset_n[*3])
    else $error("reset pulse shorter than three cycles");
  a_rst_desel: assert property (!flash_reset_n |-> flash_cs_n)
    else $error("reset pulse while selected");
  a_sclk_shape: assert property ($rose(flash_sclk) |=> flash_sclk ##1 !flash_sclk)
    else $error("serial clock high phase not two cycles");
  a_quiet_power: assert property ($fell(flash_cs_n) |-> pwr_cnt >= POWER_WAIT_CYC)
    else $error("frame started during power wait");

  c_long_frame: cover property ($rose(flash_cs_n) && n_clk == 6'd33);
  c_byte_frame: cover property ($rose(flash_cs_n) && n_clk == 6'd8);
  c_ext_exit: cover property ($rose(flash_cs_n) && n_clk == 6'd25);
  c_hw_reset: cover property ($fell(flash_reset_n));
endmodule

bind xpr_host xpr_host_asserts #(.POWER_WAIT_CYC(POWER_WAIT_CYC)) u_chk
(
  .clk                     (clk),
  .nrst                    (nrst),
  .flash_sclk              (flash_sclk),
  .flash_cs_n              (flash_cs_n),
  .flash_reset_n           (flash_reset_n),
  .serial_data_line_0_out  (serial_data_line_0_out),
  .serial_data_line_0_oe_n (serial_data_line_0_oe_n),
  .data_line_3_hold_out    (data_line_3_hold_out),
  .data_line_3_hold_oe_n   (data_line_3_hold_oe_n)
);

/* File: xpr_pkg.sv */
// types shared by the recovery controller and its frame engine
// assumes xpr_defs.svh is on the include path
package xpr_pkg;

  typedef enum logic [1:0] {OP_EXIT, OP_RECOVER, OP_HWRST, OP_SWRST} xpr_op_t;
  typedef enum logic [1:0] {PR_EXT, PR_DUAL, PR_QUAD, PR_UNKNOWN} xpr_proto_t;
  typedef enum logic [2:0] {M_POWER, M_IDLE, M_FRAME, M_FWAIT, M_RSTLOW, M_RECOV} xpr_mstate_t;
  typedef enum logic [2:0] {F_IDLE, F_SETUP, F_HIGH, F_LOW, F_GAP} xpr_fphase_t;

  // one chip-select frame: clock count and the byte sent first on data line 0
  typedef struct packed {
    logic [5:0] len;
    logic [7:0] data;
  } xpr_frame_t;

  // flash pins driven by the controller
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic dq0_out;
    logic dq0_oe_n;
    logic dq3_out;
    logic dq3_oe_n;
  } xpr_pins_t;

endpackage
